/* clsc_pkg.sv */
// Package of constants and types for the unit launch and stop controller
// Contract
// RULE1: A launch naming no unit picks a currently free unit as target.
// RULE2: Launch copies 496 consecutive long words from main memory into local RAM.
// RULE3: After the copy the boot parameter register takes the launch parameter.
// RULE4: Launch clears every other special register of the target unit.
// RULE5: When loading ends the unit starts executing at local address zero.
// RULE6: Only parameter bits 2..15 pass; the two lowest bits read zero.
// RULE7: Requester shifts plain values left by two; launched code shifts back.
// RULE8: Stop names a unit index 0..7 and affects only that unit.
// RULE9: Stop makes the unit dormant and gates off its clock; a stop of a unit being launched or loading is ignored and it still starts.
// RULE10: Launch into any free unit reports its index, or minus one.
// RULE11: Launch naming a unit stops and restarts it, even itself.
// RULE12: Boot parameter register is readable, not writable, by launched code.
// RULE13: No execution before copy and init finish; loading unit counts busy.
// RULE14: A stopped unit counts as free again.
package clsc_pkg;
  localparam int NUM_UNITS = 8;
  localparam int IDX_W = 3;
  localparam int COPY_LONGS = 496;
  localparam int LADDR_W = 9;
  localparam int HADDR_W = 16;
  localparam logic [8:0] COPY_LAST = 9'h1ef;
  localparam logic [3:0] RESULT_NONE = 4'hf;
  localparam logic [15:0] PARAM_MASK = 16'hfffc;
  localparam logic [15:0] LONG_STEP = 16'h0004;
  localparam logic [7:0] UNITS_RESET = 8'h00;

  typedef enum logic [1:0] {
    CLSC_IDLE = 2'b00,
    CLSC_READ = 2'b01,
    CLSC_WAIT = 2'b10,
    CLSC_INIT = 2'b11
  } clsc_state_t;
endpackage

/* clsc_pick.sv */
// Free unit picker: lowest-numbered free unit
`timescale 1ns/100ps
`default_nettype none
module clsc_pick (
  input wire logic [7:0] free_mask,
  output logic found,
  output logic [2:0] index
);
  always_comb begin
    found = 1'b0;
    index = 3'h0;
    for (int i = clsc_pkg::NUM_UNITS - 1; i >= 0; i--) begin
      if (free_mask[i]) begin
        found = 1'b1;
        index = 3'(i);
      end
    end
  end
endmodule
`default_nettype wire

/* clsc_top.sv */
// Launch and stop controller for eight processing units
`timescale 1ns/100ps
`default_nettype none
module clsc_top (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic LAUNCH_REQ,
  input wire logic LAUNCH_ANY,
  input wire logic [2:0] LAUNCH_UNIT,
  input wire logic [15:0] LAUNCH_CODE_ADDR,
  input wire logic [15:0] LAUNCH_PARAM,
  input wire logic STOP_REQ,
  input wire logic [2:0] STOP_UNIT,
  output logic BUSY,
  output logic DONE,
  output logic [3:0] RESULT,
  output logic MEM_RD,
  output logic [15:0] MEM_ADDR,
  input wire logic MEM_ACK,
  input wire logic [31:0] MEM_RDATA,
  output logic RAM_WE,
  output logic [2:0] RAM_UNIT,
  output logic [8:0] RAM_ADDR,
  output logic [31:0] RAM_WDATA,
  output logic [7:0] UNIT_CLK_EN,
  output logic [7:0] UNIT_START,
  output logic [7:0] UNIT_SPR_CLEAR,
  output logic [15:0] BOOT_PARAM [8]
);
  clsc_pkg::clsc_state_t state_reg;
  logic [7:0] running_reg;
  logic [7:0] loading_reg;
  logic [2:0] target_reg;
  logic [15:0] param_reg;
  logic [8:0] count_reg;
  logic pick_found;
  logic [2:0] pick_index;
  logic [7:0] free_mask;
  logic accept;
  logic launch_ok;
  logic [2:0] launch_target;
  logic copy_last;

  // --------------------------------------------------------------
  // Free unit selection
  // --------------------------------------------------------------
  assign free_mask = ~(running_reg | loading_reg); // RULE13 RULE14
  clsc_pick u_pick (
    .free_mask(free_mask),
    .found(pick_found),
    .index(pick_index)
  );
  assign accept = LAUNCH_REQ && (state_reg == clsc_pkg::CLSC_IDLE);
  assign launch_ok = accept && (!LAUNCH_ANY || pick_found);
  assign launch_target = LAUNCH_ANY ? pick_index : LAUNCH_UNIT; // RULE1 RULE11
  assign copy_last = (count_reg == clsc_pkg::COPY_LAST);

  // --------------------------------------------------------------
  // Launch sequencer
  // --------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      state_reg <= clsc_pkg::CLSC_IDLE;
      target_reg <= 3'h0;
      param_reg <= 16'h0000;
      count_reg <= 9'h000;
      MEM_RD <= 1'b0;
      MEM_ADDR <= 16'h0000;
    end else begin
      case (state_reg)
        clsc_pkg::CLSC_IDLE: begin
          if (launch_ok) begin
            target_reg <= launch_target;
            param_reg <= LAUNCH_PARAM & clsc_pkg::PARAM_MASK; // RULE6
            count_reg <= 9'h000;
            MEM_ADDR <= LAUNCH_CODE_ADDR & clsc_pkg::PARAM_MASK; // RULE2
            MEM_RD <= 1'b1;
            state_reg <= clsc_pkg::CLSC_WAIT;
          end
        end
        clsc_pkg::CLSC_READ: begin
          MEM_RD <= 1'b1;
          state_reg <= clsc_pkg::CLSC_WAIT;
        end
        clsc_pkg::CLSC_WAIT: begin
          if (MEM_ACK) begin
            MEM_RD <= 1'b0;
            if (copy_last) begin
              state_reg <= clsc_pkg::CLSC_INIT; // RULE2
            end else begin
              count_reg <= count_reg + 9'h001;
              MEM_ADDR <= MEM_ADDR + clsc_pkg::LONG_STEP;
              state_reg <= clsc_pkg::CLSC_READ;
            end
          end
        end
        clsc_pkg::CLSC_INIT: begin
          state_reg <= clsc_pkg::CLSC_IDLE;
        end
        default: begin
          state_reg <= clsc_pkg::CLSC_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // Local RAM write port
  // --------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      RAM_WE <= 1'b0;
      RAM_UNIT <= 3'h0;
      RAM_ADDR <= 9'h000;
      RAM_WDATA <= 32'h00000000;
    end else begin
      RAM_WE <= (state_reg == clsc_pkg::CLSC_WAIT) && MEM_ACK; // RULE2
      RAM_UNIT <= target_reg;
      RAM_ADDR <= count_reg;
      RAM_WDATA <= MEM_RDATA;
    end
  end

  // --------------------------------------------------------------
  // Unit run state, clock gating and start
  // --------------------------------------------------------------
  // A launch of a named unit also kills it at once, so it never runs stale code.
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      running_reg <= clsc_pkg::UNITS_RESET;
      loading_reg <= clsc_pkg::UNITS_RESET;
      UNIT_CLK_EN <= clsc_pkg::UNITS_RESET;
      UNIT_START <= clsc_pkg::UNITS_RESET;
      UNIT_SPR_CLEAR <= clsc_pkg::UNITS_RESET;
    end else begin
      for (int i = 0; i < clsc_pkg::NUM_UNITS; i++) begin
        UNIT_START[i] <= 1'b0;
        UNIT_SPR_CLEAR[i] <= 1'b0;
        if (STOP_REQ && STOP_UNIT == 3'(i)) begin
          running_reg[i] <= 1'b0; // RULE8 RULE9 RULE14
          UNIT_CLK_EN[i] <= 1'b0;
        end
        if (launch_ok && launch_target == 3'(i)) begin
          running_reg[i] <= 1'b0; // RULE11
          loading_reg[i] <= 1'b1; // RULE13
          UNIT_CLK_EN[i] <= 1'b0;
        end
        if (state_reg == clsc_pkg::CLSC_INIT && target_reg == 3'(i)) begin
          loading_reg[i] <= 1'b0;
          running_reg[i] <= 1'b1;
          UNIT_CLK_EN[i] <= 1'b1;
          UNIT_START[i] <= 1'b1; // RULE5
          UNIT_SPR_CLEAR[i] <= 1'b1; // RULE4
        end
      end
    end
  end

  // --------------------------------------------------------------
  // Boot parameter registers, no write path from the unit
  // --------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      for (int i = 0; i < clsc_pkg::NUM_UNITS; i++) begin
        BOOT_PARAM[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < clsc_pkg::NUM_UNITS; i++) begin
        if (state_reg == clsc_pkg::CLSC_INIT && target_reg == 3'(i)) begin
          BOOT_PARAM[i] <= param_reg; // RULE3 RULE12
        end
      end
    end
  end

  // --------------------------------------------------------------
  // Request answer
  // --------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      BUSY <= 1'b0;
      DONE <= 1'b0;
      RESULT <= clsc_pkg::RESULT_NONE;
    end else begin
      BUSY <= launch_ok || (state_reg != clsc_pkg::CLSC_IDLE && state_reg != clsc_pkg::CLSC_INIT);
      DONE <= accept;
      if (accept) begin
        RESULT <= launch_ok ? {1'b0, launch_target} : clsc_pkg::RESULT_NONE; // RULE10
      end
    end
  end

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  sequence launch_taken_s;
    launch_ok && LAUNCH_ANY;
  endsequence

  any_target_free_a: // RULE1
    assert property (@(posedge CLOCK) disable iff (!RESETN)
      launch_taken_s |-> free_mask[pick_index])
    else $error("Any-unit launch chose a busy unit");

  copy_count_a: // RULE2
    assert property (@(posedge CLOCK) disable iff (!RESETN)
      (state_reg == clsc_pkg::CLSC_INIT) |-> $past(count_reg) == clsc_pkg::COPY_LAST)
    else $error("Copy did not end after 496 longs");

  boot_param_load_a: // RULE3
    assert property (@(posedge CLOCK) disable iff (!RESETN)
      (state_reg == clsc_pkg::CLSC_INIT) |=> BOOT_PARAM[target_reg] == param_reg)
    else $error("Boot parameter not loaded");

  spr_clear_a: // RULE4
    assert property (@(posedge CLOCK) disable iff (!RESETN)
      (state_reg == clsc_pkg::CLSC_INIT) |=> UNIT_SPR_CLEAR[target_reg] && UNIT_START[target_reg])
    else $error("Special registers not cleared at start");

  start_after_load_a: // RULE5
    assert property (@(posedge CLOCK) disable iff (!RESETN)
      $rose(UNIT_START[target_reg]) |-> $past(state_reg) == clsc_pkg::CLSC_INIT)
    else $error("Unit started before loading ended");

  param_aligned_a: // RULE6
    assert property (@(posedge CLOCK) disable iff (!RESETN)
      BOOT_PARAM[target_reg][1:0] == 2'b00)
    else $error("Boot parameter not long aligned");

  stop_gates_a: // RULE9
    assert property (@(posedge CLOCK) disable iff (!RESETN)
      STOP_REQ && !(launch_ok && launch_target == STOP_UNIT)
      && !(state_reg == clsc_pkg::CLSC_INIT && target_reg == STOP_UNIT)
      |=> !UNIT_CLK_EN[$past(STOP_UNIT)])
    else $error("Stopped unit still clocked");

  result_none_a: // RULE10
    assert property (@(posedge CLOCK) disable iff (!RESETN)
      accept && LAUNCH_ANY && !pick_found |=> RESULT == clsc_pkg::RESULT_NONE && DONE)
    else $error("No minus one when no unit free");

  named_restart_a: // RULE11
    assert property (@(posedge CLOCK) disable iff (!RESETN)
      launch_ok && !LAUNCH_ANY |=> !UNIT_CLK_EN[target_reg] && loading_reg[target_reg])
    else $error("Named unit not halted for relaunch");
endmodule
`default_nettype wire

/* clsc_mem_model.sv */
// Main memory model answering the controller's long-word reads
`timescale 1ns/100ps
`default_nettype none
module clsc_mem_model (
  input wire logic clock,
  input wire logic resetn,
  input wire logic mem_rd,
  input wire logic [15:0] mem_addr,
  input wire logic [1:0] latency,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [1:0] wait_reg;

  // Data is address-tagged; idle data toggles so stale words never match
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wait_reg <= 2'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 32'h5a5aa5a5;
    end else if (mem_rd && !mem_ack && wait_reg == latency) begin
      wait_reg <= 2'h0;
      mem_ack <= 1'b1;
      mem_rdata <= {mem_addr, ~mem_addr};
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_rd && !mem_ack) begin
        wait_reg <= wait_reg + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* test_core_launch_stop_control.sv */
// Self-checking testbench of the launch and stop controller
`timescale 1ns/100ps
`default_nettype none
module test_core_launch_stop_control;
  logic clock = 1'b0;
  logic resetn, launch_req, launch_any, stop_req, busy, done, mem_rd, mem_ack, ram_we;
  logic [2:0] launch_unit, stop_unit, ram_unit, tgt;
  logic [15:0] code_addr, param, mem_addr, base, wa;
  logic [3:0] result;
  logic [31:0] mem_rdata, ram_wdata;
  logic [8:0] ram_addr;
  logic [7:0] clk_en, start, spr_clear, exp_en;
  logic [15:0] boot_param [8];
  logic [1:0] latency;
  int n_mismatch = 0;
  int checks_done = 0;
  int nwr, ndone;

  clsc_top u_clsc_top (.CLOCK(clock), .RESETN(resetn), .LAUNCH_REQ(launch_req),
    .LAUNCH_ANY(launch_any), .LAUNCH_UNIT(launch_unit), .LAUNCH_CODE_ADDR(code_addr),
    .LAUNCH_PARAM(param), .STOP_REQ(stop_req), .STOP_UNIT(stop_unit), .BUSY(busy),
    .DONE(done), .RESULT(result), .MEM_RD(mem_rd), .MEM_ADDR(mem_addr),
    .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata), .RAM_WE(ram_we), .RAM_UNIT(ram_unit),
    .RAM_ADDR(ram_addr), .RAM_WDATA(ram_wdata), .UNIT_CLK_EN(clk_en),
    .UNIT_START(start), .UNIT_SPR_CLEAR(spr_clear), .BOOT_PARAM(boot_param));

  clsc_mem_model u_clsc_mem_model (.clock(clock), .resetn(resetn), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .latency(latency), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  initial forever #50 clock = ~clock;

  task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task test_done;
    if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------
  // Monitor, sampled mid-cycle
  // ----------------------------------------
  always @(negedge clock) begin
    if (ram_we === 1'b1) begin
      wa = base + 16'(nwr * 4);
      cmp("ram_addr", nwr, ram_addr);
      cmp("ram_wdata", {wa, ~wa}, ram_wdata);
      cmp("ram_unit", tgt, ram_unit);
      cmp("mem_rd", 0, mem_rd);
      nwr++;
    end
    if (start !== 8'h00) begin
      cmp("words_before_start", 496, nwr);
      cmp("spr_clear", start, spr_clear);
    end
    if (done === 1'b1) ndone++;
    if (busy === 1'b1) cmp("clk_en_loading", exp_en, clk_en);
  end

  task launch(input logic any, input logic [2:0] u, input logic [15:0] a,
              input logic [15:0] p, input logic [3:0] r);
    int k;
    @(posedge clock);
    #1;
    tgt = any ? r[2:0] : u;
    base = a & 16'hfffc;
    nwr = 0;
    ndone = 0;
    if (r != 4'hf) exp_en[tgt] = 1'b0;
    launch_any = any;
    launch_unit = u;
    code_addr = a;
    param = p;
    launch_req = 1'b1;
    @(posedge clock);
    #1;
    launch_req = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 4) begin
      @(posedge clock);
      #1;
      k++;
    end
    cmp("result", r, result);
    cmp("busy", 32'(r != 4'hf), busy);
    k = 0;
    // Second request mid-copy must be ignored
    while (r != 4'hf && start === 8'h00 && k < 4000) begin
      @(posedge clock);
      #1;
      k++;
      launch_req = (k == 100);
    end
    if (r != 4'hf) begin
      exp_en[tgt] = 1'b1;
      cmp("start", 8'h01 << tgt, start);
      cmp("boot_param", p & 16'hfffc, boot_param[tgt]);
      cmp("busy_end", 0, busy);
    end
    @(posedge clock);
    #1;
    cmp("clk_en", exp_en, clk_en);
    cmp("done_count", 1, ndone);
  endtask

  task stop(input logic [2:0] u);
    @(posedge clock);
    #1;
    stop_unit = u;
    stop_req = 1'b1;
    @(posedge clock);
    #1;
    stop_req = 1'b0;
    exp_en[u] = 1'b0;
    @(posedge clock);
    #1;
    cmp("clk_en_stop", exp_en, clk_en);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    launch_req = 1'b0;
    launch_any = 1'b0;
    launch_unit = 3'h0;
    code_addr = 16'h0000;
    param = 16'h0000;
    stop_req = 1'b0;
    stop_unit = 3'h0;
    latency = 2'h0;
    exp_en = 8'h00;
    nwr = 0;
    base = 16'h0000;
    tgt = 3'h0;
    repeat (8) @(posedge clock);
    #1;
    resetn = 1'b1;
    cmp("result_reset", 4'hf, result);
    cmp("clk_en_reset", 8'h00, clk_en);
    // The last base wraps past the top of memory
    for (int i = 0; i < 8; i++) begin
      latency = 2'(i % 3);
      launch(1'b1, 3'h0, 16'hc102 + 16'(i * 2048), 16'h1233 + 16'(i), 4'(i));
    end
    launch(1'b1, 3'h0, 16'h0000, 16'h0000, 4'hf);
    stop(3'h6);
    stop(3'h3);
    launch(1'b1, 3'h0, 16'h4000, {14'h2abc, 2'b00}, 4'h3);
    launch(1'b0, 3'h5, 16'h2004, 16'hffff, 4'h5);
    launch(1'b0, 3'h6, 16'h0000, 16'h0007, 4'h6);
    test_done;
  end

  initial begin
    #4000000;
    n_mismatch++;
    test_done;
  end
endmodule
`default_nettype wire
